/* File: rtl/rxf_consts.svh */
// Purpose: constants for the receive fifo flush and flow control block
// Assumes: single clock, synchronous active low reset
// Notes: positions are bit indices within the third receive command word
`ifndef RXF_CONSTS_SVH
`define RXF_CONSTS_SVH
`define WAKE_FLAG_BIT 15
`define FAIL_FLAG_BIT 14
`define DATA_W 32
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define LVL_W 4
`define DIS_CYCLES 4'h2
`define FLUSH_CYCLES 4'h2
`endif

/* File: rtl/rxf_pkg.sv */
// Purpose: types shared by the receive fifo block
// Assumes: constants header included first
// Notes: state codes are one-hot
`include "rxf_consts.svh"
package rxf_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_DISABLING = 4'h2,
    ST_DISABLED = 4'h4,
    ST_FLUSH = 4'h8
  } ctl_state_t;
endpackage

/* File: rtl/fifo_if.sv */
// Purpose: bundle between the control block and its fifo
// Assumes: one clock
// Notes: flush clears both pointers
`timescale 1ns/1ps
interface fifo_if;
  logic [`DATA_W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [`DATA_W-1:0] rdata;
  logic rvalid;
  logic rready;
  logic flush;
  logic [`LVL_W-1:0] level;
  modport ctl (output wdata, wvalid, rready, flush, input wready, rdata, rvalid, level);
  modport mem (input wdata, wvalid, rready, flush, output wready, rdata, rvalid, level);
endinterface

/* File: rtl/rx_fifo_buf.sv */
// Purpose: parameterised fifo with valid/ready on both sides
// Assumes: synchronous flush, first word fall through
// Notes: level counts words held
`timescale 1ns/1ps
module rx_fifo_buf #(
  parameter int WIDTH = `DATA_W,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW = `FIFO_AW
) (
  input wire logic clk_in, // clock
  input wire logic rstn_in, // sync reset, low
  fifo_if.mem f // fifo bundle
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } buf_state_t;
  buf_state_t s_r, s_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic do_w, do_r;

  // handshake terms
  assign f.wready = (s_r.cnt != AW'(0) + (AW+1)'(DEPTH)) && !f.flush;
  assign f.rvalid = (s_r.cnt != '0) && !f.flush;
  assign f.rdata = mem_r[s_r.rp];
  assign f.level = `LVL_W'(s_r.cnt);
  assign do_w = f.wvalid && f.wready;
  assign do_r = f.rready && f.rvalid;

  // pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (f.flush) begin
      s_nxt = '0;
    end else begin
      if (do_w) s_nxt.wp = s_r.wp + AW'(1);
      if (do_r) s_nxt.rp = s_r.rp + AW'(1);
      s_nxt.cnt = s_r.cnt + (AW+1)'(do_w) - (AW+1)'(do_r);
    end
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (!rstn_in) s_r <= '0;
    else s_r <= s_nxt;
  end

  // storage
  always_ff @(posedge clk_in) begin
    if (do_w) mem_r[s_r.wp] <= f.wdata;
  end
endmodule

/* File: rtl/rx_fifo_flush_flow_control.sv */
// What this block does
// - set wake flag bit 15 on remote wakeup
// - set filter fail bit 14 on failed wakeup
// - filter fail only together with wake flag
// - flush returns both pointers to reset
// - flag fifo disabled and irq when done
// - host sets reset, hardware clears when flushed
// - irq holds until both disabled flags clear
// - irq visible in status and endpoint
// - receiver halted sets status and irq
// - flow on when level exceeds on threshold
// - pause frame on flow on if enabled
// - flow off when level below off threshold
// - zero pause on flow off if enabled
// Purpose: receive fifo control, flush sequence and flow control toward the mac
// Assumes: host and mac logic outside keep the stop/enable ordering
// Notes: status bits clear by write-one pulses from the host ports
`timescale 1ns/1ps
`include "rxf_consts.svh"
module rx_fifo_flush_flow_control (
  input wire logic CLK_IN, // 250 MHz clock
  input wire logic RSTN_IN, // sync reset, low
  input wire logic [`DATA_W-1:0] MAC_DATA_IN, // word from mac receiver
  input wire logic MAC_VALID_IN, // word valid
  output logic MAC_READY_OUT, // fifo can take word
  input wire logic MAC_CMDC_IN, // current word is the third command word
  input wire logic MAC_WAKE_IN, // frame caused remote wakeup
  input wire logic MAC_FILT_FAIL_IN, // frame failed filter rules
  input wire logic DEEP_SUSPEND_IN, // deep_suspend_state active
  input wire logic KEEP_WAKE_IN, // keep wake frame setting
  input wire logic ALWAYS_PASS_WAKE_IN, // always_pass_wake setting
  output logic [`DATA_W-1:0] HOST_DATA_OUT, // word to host path
  output logic HOST_VALID_OUT, // word valid
  input wire logic HOST_READY_IN, // host takes word
  input wire logic FIFO_RX_EN_IN, // fifo receive enable
  input wire logic FIFO_RESET_SET_IN, // pulse: host sets fifo reset bit
  output logic FIFO_RESET_OUT, // fifo reset bit, cleared by hardware
  output logic FIFO_DISABLED_OUT, // fifo disabled status
  input wire logic FIFO_DIS_CLR_IN, // pulse: clear fifo disabled status
  input wire logic MAC_HALTED_IN, // mac receiver has halted (pulse or level)
  output logic RX_HALTED_OUT, // receiver halted status
  input wire logic RX_HALT_CLR_IN, // pulse: clear receiver halted status
  input wire logic RX_DIS_IRQ_EN_IN, // rx_disabled_irq enable
  output logic RX_DIS_IRQ_OUT, // rx_disabled_irq in irq_status_reg / endpoint
  input wire logic [`LVL_W-1:0] FLOW_ON_THR_IN, // on threshold, words
  input wire logic [`LVL_W-1:0] FLOW_OFF_THR_IN, // off threshold, words
  input wire logic PAUSE_TX_EN_IN, // pause_tx_enable
  output logic FLOW_ON_OUT, // one-cycle flow-control-on
  output logic FLOW_OFF_OUT, // one-cycle flow-control-off
  output logic PAUSE_REQ_OUT, // one-cycle pause request
  output logic PAUSE_ZERO_OUT // pause request carries zero value
);
  typedef struct packed {
    rxf_pkg::ctl_state_t st;
    logic [3:0] cnt;
    logic rst_bit;
    logic fifo_dis;
    logic rx_halt;
    logic irq;
    logic flow_hi;
    logic on_p;
    logic off_p;
    logic pause;
    logic pzero;
    logic [`DATA_W-1:0] hdata;
    logic hvalid;
    logic mready;
  } ctl_t;
  ctl_t s_r, s_nxt;
  fifo_if f ();
  logic [`DATA_W-1:0] wword;
  logic wake_ok, fail_ok;
  logic hold_off;
  logic out_take;
  logic wr_go, rd_go;

  // fifo instance
  rx_fifo_buf #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_buf (
    .clk_in(CLK_IN),
    .rstn_in(RSTN_IN),
    .f(f)
  );

  // third command word flags inserted on the way in
  assign wake_ok = MAC_WAKE_IN && DEEP_SUSPEND_IN && KEEP_WAKE_IN;
  assign fail_ok = wake_ok && ALWAYS_PASS_WAKE_IN && MAC_FILT_FAIL_IN;
  always_comb begin
    wword = MAC_DATA_IN;
    if (MAC_CMDC_IN) begin
      wword[`WAKE_FLAG_BIT] = wake_ok;
      wword[`FAIL_FLAG_BIT] = fail_ok;
    end
  end

  // fifo stopped unless running and not being reset
  assign hold_off = (s_r.st != rxf_pkg::ST_RUN) || s_r.rst_bit;
  assign f.wdata = wword;
  // a word is only taken while the registered ready is shown to the mac
  assign f.wvalid = MAC_VALID_IN && s_r.mready && !hold_off;
  assign f.flush = (s_r.st == rxf_pkg::ST_FLUSH);
  // output register stage fed from the fifo
  assign out_take = !s_r.hvalid || HOST_READY_IN;
  assign f.rready = out_take && !hold_off;
  // this cycle's fifo traffic, used to predict the next fill level
  assign wr_go = f.wvalid && f.wready;
  assign rd_go = f.rready && f.rvalid;

  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.on_p = 1'b0;
    s_nxt.off_p = 1'b0;
    s_nxt.pause = 1'b0;
    s_nxt.pzero = 1'b0;
    if (FIFO_RESET_SET_IN) s_nxt.rst_bit = 1'b1;
    unique case (s_r.st)
      rxf_pkg::ST_RUN: begin
        if (!FIFO_RX_EN_IN) begin
          s_nxt.st = rxf_pkg::ST_DISABLING;
          s_nxt.cnt = `DIS_CYCLES;
        end
      end
      rxf_pkg::ST_DISABLING: begin
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          s_nxt.st = rxf_pkg::ST_DISABLED;
          s_nxt.fifo_dis = 1'b1;
        end
      end
      rxf_pkg::ST_DISABLED: begin
        if (s_r.rst_bit) begin
          s_nxt.st = rxf_pkg::ST_FLUSH;
          s_nxt.cnt = `FLUSH_CYCLES;
        end else if (FIFO_RX_EN_IN) begin
          s_nxt.st = rxf_pkg::ST_RUN;
        end
      end
      rxf_pkg::ST_FLUSH: begin
        s_nxt.hvalid = 1'b0;
        if (s_r.cnt != 4'h0) begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end else begin
          s_nxt.rst_bit = FIFO_RESET_SET_IN;
          s_nxt.st = rxf_pkg::ST_DISABLED;
        end
      end
    endcase
    // host-side output stage
    if (s_r.st != rxf_pkg::ST_FLUSH && out_take) begin
      s_nxt.hvalid = f.rvalid && !hold_off;
      s_nxt.hdata = f.rdata;
    end
    // status flags, set wins over clear
    if (FIFO_DIS_CLR_IN && !(s_r.st == rxf_pkg::ST_DISABLING && s_r.cnt == 4'h0)) begin
      s_nxt.fifo_dis = 1'b0;
    end
    if (RX_HALT_CLR_IN) s_nxt.rx_halt = 1'b0;
    if (MAC_HALTED_IN) s_nxt.rx_halt = 1'b1;
    // interrupt rises on either event, persists until both flags clear
    if (RX_DIS_IRQ_EN_IN && ((s_nxt.fifo_dis && !s_r.fifo_dis) ||
                             (s_nxt.rx_halt && !s_r.rx_halt))) begin
      s_nxt.irq = 1'b1;
    end else if (!s_nxt.fifo_dis && !s_nxt.rx_halt) begin
      s_nxt.irq = 1'b0;
    end
    // flow control with hysteresis, one-shot on crossings
    if (!s_r.flow_hi && f.level > FLOW_ON_THR_IN) begin
      s_nxt.flow_hi = 1'b1;
      s_nxt.on_p = 1'b1;
      s_nxt.pause = PAUSE_TX_EN_IN;
    end else if (s_r.flow_hi && f.level < FLOW_OFF_THR_IN) begin
      s_nxt.flow_hi = 1'b0;
      s_nxt.off_p = 1'b1;
      s_nxt.pause = PAUSE_TX_EN_IN;
      s_nxt.pzero = PAUSE_TX_EN_IN;
    end
    // ready is registered, so promise it only when a slot stays free after this edge
    s_nxt.mready = (s_nxt.st == rxf_pkg::ST_RUN) && !s_nxt.rst_bit &&
                   ((5'(f.level) + 5'(wr_go) - 5'(rd_go)) < 5'(`FIFO_DEPTH));
  end

  // state register
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      s_r <= '0;
      s_r.st <= rxf_pkg::ST_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from flops
  assign MAC_READY_OUT = s_r.mready;
  assign HOST_DATA_OUT = s_r.hdata;
  assign HOST_VALID_OUT = s_r.hvalid;
  assign FIFO_RESET_OUT = s_r.rst_bit;
  assign FIFO_DISABLED_OUT = s_r.fifo_dis;
  assign RX_HALTED_OUT = s_r.rx_halt;
  assign RX_DIS_IRQ_OUT = s_r.irq;
  assign FLOW_ON_OUT = s_r.on_p;
  assign FLOW_OFF_OUT = s_r.off_p;
  assign PAUSE_REQ_OUT = s_r.pause;
  assign PAUSE_ZERO_OUT = s_r.pzero;
endmodule

/* File: tb/rxf_asserts.sv */
// Purpose: port-level checks for the rx fifo flush and flow block
// Assumes: one clock, sync low reset
// Notes: bound to the top module at the file foot
`timescale 1ns/1ps
module rxf_asserts (
  input wire logic CLK_IN, // clock
  input wire logic RSTN_IN, // reset, low
  input wire logic FLOW_ON_OUT, // on pulse
  input wire logic FLOW_OFF_OUT, // off pulse
  input wire logic PAUSE_REQ_OUT, // pause
  input wire logic PAUSE_ZERO_OUT, // zero pause
  input wire logic PAUSE_TX_EN_IN, // pause enable
  input wire logic RX_DIS_IRQ_OUT, // irq
  input wire logic RX_DIS_IRQ_EN_IN, // irq enable
  input wire logic FIFO_DISABLED_OUT, // fifo off
  input wire logic FIFO_DIS_CLR_IN, // clear
  input wire logic RX_HALTED_OUT, // halted
  input wire logic RX_HALT_CLR_IN, // clear
  input wire logic MAC_HALTED_IN, // mac halt
  input wire logic FIFO_RESET_OUT // reset bit
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  chk_flow_exclusive: assert property (!(FLOW_ON_OUT && FLOW_OFF_OUT))
    else $error("flow on and off together");
  chk_on_one_shot: assert property (FLOW_ON_OUT |=> !FLOW_ON_OUT)
    else $error("flow on held");
  chk_off_one_shot: assert property (FLOW_OFF_OUT |=> !FLOW_OFF_OUT)
    else $error("flow off held");
  chk_pause_on: assert property (FLOW_ON_OUT |-> PAUSE_REQ_OUT == PAUSE_TX_EN_IN)
    else $error("pause on flow on wrong");
  chk_pause_zero: assert property (FLOW_OFF_OUT && PAUSE_TX_EN_IN |-> PAUSE_REQ_OUT && PAUSE_ZERO_OUT)
    else $error("zero pause missing");
  chk_halt_sets: assert property (MAC_HALTED_IN && !RX_HALT_CLR_IN |=> RX_HALTED_OUT)
    else $error("halted status not set");
  chk_irq_holds: assert property (RX_DIS_IRQ_OUT && (FIFO_DISABLED_OUT || RX_HALTED_OUT)
    && !FIFO_DIS_CLR_IN && !RX_HALT_CLR_IN |=> RX_DIS_IRQ_OUT) else $error("irq dropped early");
  chk_dis_irq: assert property ($rose(FIFO_DISABLED_OUT) && RX_DIS_IRQ_EN_IN |-> ##[0:1] RX_DIS_IRQ_OUT)
    else $error("irq missing on disable");
  chk_reset_clears: assert property ($rose(FIFO_RESET_OUT) |-> ##[1:8] !FIFO_RESET_OUT)
    else $error("reset bit not cleared");
endmodule
bind rx_fifo_flush_flow_control rxf_asserts rxf_asserts_inst (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN),
  .FLOW_ON_OUT(FLOW_ON_OUT), .FLOW_OFF_OUT(FLOW_OFF_OUT), .PAUSE_REQ_OUT(PAUSE_REQ_OUT),
  .PAUSE_ZERO_OUT(PAUSE_ZERO_OUT), .PAUSE_TX_EN_IN(PAUSE_TX_EN_IN), .RX_DIS_IRQ_OUT(RX_DIS_IRQ_OUT),
  .RX_DIS_IRQ_EN_IN(RX_DIS_IRQ_EN_IN), .FIFO_DISABLED_OUT(FIFO_DISABLED_OUT),
  .FIFO_DIS_CLR_IN(FIFO_DIS_CLR_IN), .RX_HALTED_OUT(RX_HALTED_OUT), .RX_HALT_CLR_IN(RX_HALT_CLR_IN),
  .MAC_HALTED_IN(MAC_HALTED_IN), .FIFO_RESET_OUT(FIFO_RESET_OUT));

/* File: tb/rxf_mac_model.sv */
// Purpose: mac receiver model feeding counted words
// Assumes: word taken when valid and ready both high
// Notes: idle data toggles so stale values never match
`timescale 1ns/1ps
module rxf_mac_model (
  input wire logic clk_in, // clock
  input wire logic go_in, // start burst
  input wire logic [3:0] n_in, // burst words
  input wire logic ready_in, // fifo ready
  input wire logic receiver_enable_bit_in, // receiver enable
  output logic valid_out, // word valid
  output logic [31:0] data_out, // word
  output logic halted_out // halt pulse
);
  logic [3:0] left_r = 4'h0;
  logic [31:0] cnt_r = 32'h0;
  logic receiver_enable_bit_r = 1'b1;
  initial valid_out = 1'b0;
  initial data_out = 32'h0;
  initial halted_out = 1'b0;
  // holds each word until taken; halts a cycle after enable drops
  always @(posedge clk_in) begin
    receiver_enable_bit_r <= receiver_enable_bit_in;
    halted_out <= receiver_enable_bit_r & ~receiver_enable_bit_in;
    if (valid_out && ready_in) begin
      cnt_r <= cnt_r + 32'h1;
      left_r <= left_r - 4'h1;
      valid_out <= left_r > 4'h1;
      data_out <= (left_r > 4'h1) ? cnt_r + 32'h1 : ~data_out;
    end else if (go_in) begin
      valid_out <= 1'b1;
      left_r <= n_in;
      data_out <= cnt_r;
    end else if (!valid_out) begin
      data_out <= ~data_out;
    end
  end
endmodule

/* File: tb/rx_fifo_flush_flow_control_tb.sv */
// Purpose: self-checking bench for the rx fifo flush and flow block
// Assumes: inputs change by nonblocking writes at rising edges
// Notes: outputs sampled at falling edges
`timescale 1ns/1ps
`include "rxf_consts.svh"
module rx_fifo_flush_flow_control_tb;
  logic clk = 1'b0, rstn = 1'b0, go = 1'b0, receiver_enable_bit = 1'b1, ready = 1'b1, cmdc = 1'b0, wake = 1'b0;
  logic ffail = 1'b0, fen = 1'b1, rset = 1'b0, dclr = 1'b0, hclr = 1'b0, ptx = 1'b1;
  logic ien = 1'b1;
  logic [3:0] n = 4'h0;
  logic [`DATA_W-1:0] mdata, hdata, exp_w = 32'h0;
  logic mvalid, mhalt, mready, hvalid, rbit, fdis, halted, irq, fon, foff, preq, pzero;
  int errors = 0, checks = 0, n_on = 0, n_off = 0, n_req = 0, n_zero = 0;
  always #2 clk = ~clk;
  // tally one-cycle flow and pause pulses
  always @(negedge clk) begin
    n_on += (fon === 1'b1);
    n_off += (foff === 1'b1);
    n_req += (preq === 1'b1);
    n_zero += (pzero === 1'b1);
  end
  rxf_mac_model rxf_mac_model_inst (.clk_in(clk), .go_in(go), .n_in(n), .ready_in(mready),
    .receiver_enable_bit_in(receiver_enable_bit), .valid_out(mvalid), .data_out(mdata), .halted_out(mhalt));
  rx_fifo_flush_flow_control rx_fifo_flush_flow_control_inst (.CLK_IN(clk), .RSTN_IN(rstn),
    .MAC_DATA_IN(mdata), .MAC_VALID_IN(mvalid), .MAC_READY_OUT(mready), .MAC_CMDC_IN(cmdc),
    .MAC_WAKE_IN(wake), .MAC_FILT_FAIL_IN(ffail), .DEEP_SUSPEND_IN(cmdc), .KEEP_WAKE_IN(cmdc),
    .ALWAYS_PASS_WAKE_IN(cmdc), .HOST_DATA_OUT(hdata), .HOST_VALID_OUT(hvalid),
    .HOST_READY_IN(ready), .FIFO_RX_EN_IN(fen), .FIFO_RESET_SET_IN(rset), .FIFO_RESET_OUT(rbit),
    .FIFO_DISABLED_OUT(fdis), .FIFO_DIS_CLR_IN(dclr), .MAC_HALTED_IN(mhalt),
    .RX_HALTED_OUT(halted), .RX_HALT_CLR_IN(hclr), .RX_DIS_IRQ_EN_IN(ien), .RX_DIS_IRQ_OUT(irq),
    .FLOW_ON_THR_IN(4'h5), .FLOW_OFF_THR_IN(4'h2), .PAUSE_TX_EN_IN(ptx), .FLOW_ON_OUT(fon),
    .FLOW_OFF_OUT(foff), .PAUSE_REQ_OUT(preq), .PAUSE_ZERO_OUT(pzero));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic await(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) @(negedge clk);
  endtask
  task automatic send(input logic [3:0] k);
    @(posedge clk) begin go <= 1'b1; n <= k; end
    @(posedge clk) go <= 1'b0;
  endtask
  task automatic get(input logic [31:0] e);
    @(negedge clk);
    await(hvalid, 1'b1);
    chk("host valid", 32'h1, {31'h0, hvalid});
    chk("host word", e, hdata);
    @(posedge clk);
  endtask
  task automatic t_fill;
    @(posedge clk) ready <= 1'b0;
    send(4'hA);
    await(mready, 1'b0);
    chk("mac ready", 32'h0, {31'h0, mready});
    chk("held word", 32'h1, {31'h0, mvalid});
    chk("flow on", 32'h1, n_on);
    chk("pause on", 32'h1, n_req);
    @(posedge clk) ready <= 1'b1;
    for (int i = 0; i < 10; i++) get(exp_w + i);
    exp_w += 10;
    chk("flow off", 32'h1, n_off);
    chk("zero pause", 32'h1, n_zero);
  endtask
  task automatic t_flush;
    @(posedge clk) ready <= 1'b0;
    send(4'h3);
    await(mvalid, 1'b0);
    @(posedge clk) receiver_enable_bit <= 1'b0;
    await(halted, 1'b1);
    chk("halted", 32'h1, {31'h0, halted});
    @(posedge clk) fen <= 1'b0;
    await(fdis, 1'b1);
    chk("fifo disabled", 32'h1, {31'h0, fdis});
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge clk) rset <= 1'b1;
    @(posedge clk) rset <= 1'b0;
    await(rbit, 1'b1);
    await(rbit, 1'b0);
    chk("reset bit", 32'h0, {31'h0, rbit});
    chk("flushed word", 32'h0, {31'h0, hvalid});
    @(posedge clk) dclr <= 1'b1;
    @(posedge clk) dclr <= 1'b0;
    repeat (2) @(negedge clk);
    chk("irq held", 32'h1, {31'h0, irq});
    @(posedge clk) hclr <= 1'b1;
    @(posedge clk) hclr <= 1'b0;
    await(irq, 1'b0);
    chk("irq cleared", 32'h0, {31'h0, irq});
    @(posedge clk) begin receiver_enable_bit <= 1'b1; fen <= 1'b1; ready <= 1'b1; end
    exp_w += 3;
    send(4'h1);
    get(exp_w);
    exp_w += 1;
  endtask
  task automatic t_wake;
    @(posedge clk) begin cmdc <= 1'b1; wake <= 1'b1; ffail <= 1'b1; end
    send(4'h1);
    get({exp_w[31:16], 2'b11, exp_w[13:0]});
    @(posedge clk) ffail <= 1'b0;
    send(4'h1);
    get({exp_w[31:16] , 2'b10, exp_w[13:0]} + 32'h1);
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // watchdog cuts a hang short
  initial begin
    #40000;
    errors++;
    stop_test;
  end
  // reset then run each scenario
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_fill;
    t_flush;
    t_wake;
    stop_test;
  end
endmodule
